// File: design/pin_change_interrupt_unit.sv
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/1ps

module pin_change_interrupt_unit
  import pin_change_pkg::*;
(
  input  wire logic                ref_clk,     // 40 MHz system clock
  input  wire logic                rst_n,       // synchronous reset, active low
  input  apb_req_s                 apbReq,      // APB request from master
  output apb_rsp_s                 apbRsp,      // APB answer to master
  input  wire logic [GROUP0_W-1:0] group0Pins,  // group 0 input pins
  input  wire logic [GROUP1_W-1:0] group1Pins,  // group 1 input pins
  input  wire logic [GROUP2_W-1:0] group2Pins,  // group 2 input pins
  input  wire logic [GROUPS-1:0]   vectorAck,   // service routine started, per group
  output logic      [GROUPS-1:0]   vectorReq,   // per-group vector request
  output logic                     irq          // unmasked event status pending
);

  state_s            st;
  state_s            next_st;
  logic [PINS_W-1:0] pinDiff;
  logic [GROUPS-1:0] groupHit;
  logic [GROUPS-1:0] flagClear;
  logic              setupPhase;
  logic              accessPhase;
  logic              wrAccess;
  logic              rdAccess;

  assign setupPhase  = apbReq.psel & ~apbReq.penable;
  assign accessPhase = apbReq.psel & apbReq.penable;
  assign wrAccess    = accessPhase & apbReq.pwrite;
  assign rdAccess    = accessPhase & ~apbReq.pwrite;

  // masked pins never count; compare stage only trusted once warmed up
  assign pinDiff = (st.pinSync2 ^ st.pinPrev)
                 & {st.group2PinMask, st.group1PinMask, st.group0PinMask};

  always_comb begin
    groupHit = '0;
    if (st.warm == WARM_DONE) begin
      groupHit[GROUP0_BIT] = |pinDiff[GROUP1_LSB-1:GROUP0_LSB];
      groupHit[GROUP1_BIT] = |pinDiff[GROUP2_LSB-1:GROUP1_LSB];
      groupHit[GROUP2_BIT] = |pinDiff[PINS_W-1:GROUP2_LSB];
    end
  end

  always_comb begin
    flagClear = vectorAck;
    if (wrAccess && apbReq.paddr == OFF_GROUP_FLAG) begin
      flagClear = flagClear | apbReq.pwdata[GROUPS-1:0];
    end
  end

  always_comb begin
    next_st = st;

    // first stage feeds only the second
    next_st.pinSync1 = {group2Pins, group1Pins, group0Pins};
    next_st.pinSync2 = st.pinSync1;
    next_st.pinPrev  = st.pinSync2;
    if (st.warm != WARM_DONE) begin
      next_st.warm = st.warm + 2'h1;
    end

    // a new change wins over a clear in the same cycle
    next_st.groupFlag = (st.groupFlag & ~flagClear) | groupHit;

    next_st.eventStatus = st.eventStatus;
    if (rdAccess && apbReq.paddr == OFF_EVENT_STATUS) begin
      next_st.eventStatus = '0;
    end
    next_st.eventStatus = next_st.eventStatus | groupHit;

    if (wrAccess) begin
      case (apbReq.paddr)
        OFF_GROUP_ENABLE: next_st.groupEnable   = apbReq.pwdata[GROUPS-1:0];
        OFF_GROUP0_MASK:  next_st.group0PinMask = apbReq.pwdata[GROUP0_W-1:0];
        OFF_GROUP1_MASK:  next_st.group1PinMask = apbReq.pwdata[GROUP1_W-1:0];
        OFF_GROUP2_MASK:  next_st.group2PinMask = apbReq.pwdata[GROUP2_W-1:0];
        OFF_CPU_STATUS:   next_st.globalEnable  = apbReq.pwdata[GLOBAL_IE_BIT];
        OFF_EVENT_MASK:   next_st.eventMask     = apbReq.pwdata[GROUPS-1:0];
        default: ;
      endcase
    end

    // read data captured in setup so prdata comes straight from a flop
    if (setupPhase) begin
      next_st.rdata  = '0;
      next_st.slvErr = 1'b0;
      case (apbReq.paddr)
        OFF_GROUP_ENABLE: next_st.rdata[GROUPS-1:0]   = st.groupEnable;
        OFF_GROUP_FLAG:   next_st.rdata[GROUPS-1:0]   = st.groupFlag;
        OFF_GROUP0_MASK:  next_st.rdata[GROUP0_W-1:0] = st.group0PinMask;
        OFF_GROUP1_MASK:  next_st.rdata[GROUP1_W-1:0] = st.group1PinMask;
        OFF_GROUP2_MASK:  next_st.rdata[GROUP2_W-1:0] = st.group2PinMask;
        OFF_CPU_STATUS:   next_st.rdata[GLOBAL_IE_BIT] = st.globalEnable;
        OFF_EVENT_STATUS: next_st.rdata[GROUPS-1:0]   = st.eventStatus;
        OFF_EVENT_MASK:   next_st.rdata[GROUPS-1:0]   = st.eventMask;
        OFF_PIN_LEVEL:    next_st.rdata[PINS_W-1:0]   = st.pinSync2;
        default:          next_st.slvErr              = 1'b1;
      endcase
    end

    if (!rst_n) begin
      next_st               = '0;
      next_st.groupEnable   = GROUP_ENABLE_RST;
      next_st.groupFlag     = GROUP_FLAG_RST;
      next_st.group0PinMask = GROUP0_MASK_RST;
      next_st.group1PinMask = GROUP1_MASK_RST;
      next_st.group2PinMask = GROUP2_MASK_RST;
      next_st.globalEnable  = GLOBAL_IE_RST;
      next_st.eventStatus   = EVENT_STATUS_RST;
      next_st.eventMask     = EVENT_MASK_RST;
    end
  end

  always_ff @(posedge ref_clk) begin
    st <= next_st;
  end

  // zero wait states: answer in the first access cycle
  assign apbRsp.pready  = accessPhase;
  assign apbRsp.pslverr = accessPhase & st.slvErr;
  assign apbRsp.prdata  = st.rdata;

  assign vectorReq = st.groupFlag & st.groupEnable & {GROUPS{st.globalEnable}};
  assign irq       = |(st.eventStatus & st.eventMask);

endmodule : pin_change_interrupt_unit

// File: include/pin_change_pkg.sv
package pin_change_pkg;

  // register byte offsets on the APB window
  localparam logic [7:0] OFF_GROUP_ENABLE = 8'h00;
  localparam logic [7:0] OFF_GROUP_FLAG   = 8'h04;
  localparam logic [7:0] OFF_GROUP0_MASK  = 8'h08;
  localparam logic [7:0] OFF_GROUP1_MASK  = 8'h0c;
  localparam logic [7:0] OFF_GROUP2_MASK  = 8'h10;
  localparam logic [7:0] OFF_CPU_STATUS   = 8'h14;
  localparam logic [7:0] OFF_EVENT_STATUS = 8'h18;
  localparam logic [7:0] OFF_EVENT_MASK   = 8'h1c;
  localparam logic [7:0] OFF_PIN_LEVEL    = 8'h20;

  // group layout
  localparam int GROUPS     = 3;
  localparam int GROUP0_W   = 8;
  localparam int GROUP1_W   = 7;
  localparam int GROUP2_W   = 8;
  localparam int PINS_W     = GROUP0_W + GROUP1_W + GROUP2_W;
  localparam int GROUP0_LSB = 0;
  localparam int GROUP1_LSB = GROUP0_W;
  localparam int GROUP2_LSB = GROUP0_W + GROUP1_W;

  // field positions
  localparam int GROUP0_BIT     = 0;
  localparam int GROUP1_BIT     = 1;
  localparam int GROUP2_BIT     = 2;
  localparam int GLOBAL_IE_BIT  = 0;

  // reset values
  localparam logic [GROUPS-1:0]   GROUP_ENABLE_RST = 3'h0;
  localparam logic [GROUPS-1:0]   GROUP_FLAG_RST   = 3'h0;
  localparam logic [GROUPS-1:0]   EVENT_STATUS_RST = 3'h0;
  localparam logic [GROUPS-1:0]   EVENT_MASK_RST   = 3'h0;
  localparam logic [GROUP0_W-1:0] GROUP0_MASK_RST  = 8'h00;
  localparam logic [GROUP1_W-1:0] GROUP1_MASK_RST  = 7'h00;
  localparam logic [GROUP2_W-1:0] GROUP2_MASK_RST  = 8'h00;
  localparam logic                GLOBAL_IE_RST    = 1'b0;

  // cycles from reset release until the compare stage holds two real samples
  localparam logic [1:0] WARM_DONE = 2'h3;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_s;

  typedef struct packed {
    logic [GROUPS-1:0]   groupEnable;
    logic [GROUPS-1:0]   groupFlag;
    logic [GROUP0_W-1:0] group0PinMask;
    logic [GROUP1_W-1:0] group1PinMask;
    logic [GROUP2_W-1:0] group2PinMask;
    logic                globalEnable;
    logic [GROUPS-1:0]   eventStatus;
    logic [GROUPS-1:0]   eventMask;
    logic [PINS_W-1:0]   pinSync1;
    logic [PINS_W-1:0]   pinSync2;
    logic [PINS_W-1:0]   pinPrev;
    logic [1:0]          warm;
    logic [31:0]         rdata;
    logic                slvErr;
  } state_s;

endpackage : pin_change_pkg

// File: bench/pcint_asserts.sv
`timescale 1ns/1ps
module pcint_asserts
  import pin_change_pkg::*;
(
  input wire logic                ref_clk,    // clk
  input wire logic                rst_n,      // rst
  input apb_req_s                 apbReq,     // req
  input apb_rsp_s                 apbRsp,     // rsp
  input wire logic [GROUP0_W-1:0] group0Pins, // pins
  input wire logic [GROUP1_W-1:0] group1Pins, // pins
  input wire logic [GROUP2_W-1:0] group2Pins, // pins
  input wire logic [GROUPS-1:0]   vectorAck,  // ack
  input wire logic [GROUPS-1:0]   vectorReq,  // req
  input wire logic                irq         // irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic [PINS_W-1:0] h1, h2, h3;
  always_ff @(posedge ref_clk) {h3, h2, h1} <= {h2, h1, group2Pins, group1Pins, group0Pins};
  // a flag sets from pins two and three edges back
  wire [PINS_W-1:0] chg = h2 ^ h3;
  wire wrAcc = apbReq.psel && apbReq.penable && apbReq.pwrite;
  wire c0 = |chg[7:0] || wrAcc;
  wire c2 = |chg[22:15] || wrAcc;
  sequence cause0; $past(c0); endsequence
  quiet_rst_a: assert property (disable iff (1'b0) !rst_n |=> !vectorReq && !irq)
    else $error("req after reset");
  rise_cause_a: assert property ($rose(vectorReq[0]) |-> cause0)
    else $error("req0 no cause");
  rise2_cause_a: assert property ($rose(vectorReq[2]) |-> $past(c2))
    else $error("req2 no cause");
  ack1_clear_a: assert property (vectorAck[1] && !(|chg[14:8]) |=> !vectorReq[1])
    else $error("ack1 kept");
  ack0_clear_a: assert property (vectorAck[0] && !(|chg[7:0]) |=> !vectorReq[0])
    else $error("ack0 kept");
  w1c_clear_a: assert property (wrAcc && apbReq.paddr == OFF_GROUP_FLAG && apbReq.pwdata[2]
    && !(|chg[22:15]) |=> !vectorReq[2]) else $error("w1c kept");
  zero_keep_a: assert property (vectorReq[0] && !vectorAck[0] && !(wrAcc &&
    (apbReq.paddr != OFF_GROUP_FLAG || apbReq.pwdata[0])) |=> vectorReq[0]) else $error("lost");
  res_zero_a: assert property (apbReq.psel && apbReq.penable && !apbReq.pwrite
    && apbReq.paddr <= OFF_GROUP_FLAG |-> apbRsp.prdata[31:3] == '0) else $error("res bits");
endmodule : pcint_asserts
bind pin_change_interrupt_unit pcint_asserts u_chk (.ref_clk, .rst_n, .apbReq, .apbRsp,
  .group0Pins, .group1Pins, .group2Pins, .vectorAck, .vectorReq, .irq);

// File: bench/cpu_service_model.sv
`timescale 1ns/1ps
module cpu_service_model
  import pin_change_pkg::*;
(
  input  wire logic              ref_clk,   // clk
  input  wire logic              rst_n,     // rst
  input  wire logic [1:0]        mode,      // 0 off, 1 prompt, 2 slow
  input  wire logic [GROUPS-1:0] vectorReq, // pending
  output logic      [GROUPS-1:0] vectorAck  // routine entry
);
  logic [3:0] waitCnt;
  always_ff @(posedge ref_clk) begin
    vectorAck <= '0;
    if (!rst_n || mode == 2'h0 || !vectorReq || vectorAck != '0) begin
      waitCnt <= '0;
    end else if (waitCnt >= (mode == 2'h1 ? 4'h1 : 4'h9)) begin
      vectorAck <= vectorReq & (~vectorReq + 3'h1);
      waitCnt   <= '0;
    end else begin
      waitCnt <= waitCnt + 4'h1;
    end
  end
endmodule : cpu_service_model

// File: bench/test_pin_change_interrupt_unit.sv
`timescale 1ns/1ps
module test_pin_change_interrupt_unit
  import pin_change_pkg::*;
();
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  apb_req_s apbReq = '0;
  apb_rsp_s apbRsp;
  logic [PINS_W-1:0] pins = '0;
  logic [GROUPS-1:0] vectorAck, vectorReq;
  logic irq;
  logic [1:0] mode = 2'h0;
  // bit 32 carries the expected error flag, the low word the read data
  logic [32:0] expQ[$];
  logic [32:0] expNow;
  int miscompares = 0, num_checks = 0, seed = 85;
  int lsb[3] = '{0, 8, 15};
  always #12.5 ref_clk = ~ref_clk;
  pin_change_interrupt_unit u_dut (.ref_clk, .rst_n, .apbReq, .apbRsp, .group0Pins(pins[7:0]),
    .group1Pins(pins[14:8]), .group2Pins(pins[22:15]), .vectorAck, .vectorReq, .irq);
  cpu_service_model u_cpu (.ref_clk, .rst_n, .mode, .vectorReq, .vectorAck);
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk
  task automatic final_report;
    $display("checks=%0d miscompares=%0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  // one idle edge first so a release and a new setup never share a step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    apbReq <= '{1'b1, 1'b0, w, a, d};
    @(posedge ref_clk);
    apbReq.penable <= 1'b1;
    do @(posedge ref_clk); while (apbRsp.pready !== 1'b1);
    apbReq <= '0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    // nothing is mapped above the pin level word, so those reads must flag an error
    expQ.push_back({a > OFF_PIN_LEVEL, e});
    apb(1'b0, a, '0);
  endtask : rd
  task automatic tog(input int i);
    pins[i] <= ~pins[i];
    repeat (6) @(posedge ref_clk);
  endtask : tog
  always @(posedge ref_clk)
    if (apbReq.psel && apbReq.penable && apbRsp.pready === 1'b1 && !apbReq.pwrite) begin
      expNow = expQ.pop_front();
      chk(expNow[31:0], apbRsp.prdata);
      chk(32'(expNow[32]), 32'(apbRsp.pslverr));
    end
  initial begin
    repeat (4000) @(posedge ref_clk);
    miscompares++;
    final_report();
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int a = 0; a <= 36; a += 4) rd(8'(a), '0);
    apb(1'b1, OFF_GROUP_ENABLE, '1);
    rd(OFF_GROUP_ENABLE, 32'h7);
    apb(1'b1, OFF_GROUP_ENABLE, '0);
    apb(1'b1, OFF_CPU_STATUS, 32'h1);
    apb(1'b1, OFF_EVENT_MASK, 32'h7);
    for (int g = 0; g < 3; g++) begin
      apb(1'b1, OFF_GROUP0_MASK + 8'(4 * g), 32'hfe);
      tog(lsb[g]);
      rd(OFF_GROUP_FLAG, '0);
      tog(lsb[g] + 1 + {$random(seed)} % (g == 1 ? 6 : 7));
      chk(32'(irq), 32'h1);
      chk(32'(vectorReq), '0);
      apb(1'b1, OFF_GROUP_FLAG, '0);
      rd(OFF_GROUP_FLAG, 32'h1 << g);
      rd(OFF_EVENT_STATUS, 32'h1 << g);
      @(posedge ref_clk);
      chk(32'(irq), '0);
      apb(1'b1, OFF_GROUP_FLAG, 32'h1 << g);
      rd(OFF_GROUP_FLAG, '0);
    end
    apb(1'b1, OFF_EVENT_MASK, '0);
    tog(3);
    chk(32'(irq), '0);
    apb(1'b1, OFF_EVENT_MASK, 32'h7);
    @(posedge ref_clk);
    chk(32'(irq), 32'h1);
    apb(1'b1, OFF_GROUP_ENABLE, 32'h7);
    for (int m = 1; m < 3; m++) begin
      mode <= 2'(m);
      tog(9);
      if (m == 2) chk(32'(vectorReq), 32'h2);
      repeat (12) @(posedge ref_clk);
      rd(OFF_GROUP_FLAG, '0);
    end
    // slow service still on: group 2 must raise its own request line
    tog(16);
    chk(32'(vectorReq), 32'h4);
    repeat (12) @(posedge ref_clk);
    rd(OFF_GROUP_FLAG, '0);
    rd(OFF_PIN_LEVEL, 32'(pins));
    final_report();
  end
endmodule : test_pin_change_interrupt_unit
